// ==== core/ascm_pkg.sv ====
// constants and types shared by the self-driven serial configuration loader
package ascm_pkg;
   // mode select codes, bit 3 down to bit 0
   localparam logic [3:0]  MODE_STD_POR      = 4'h2;       // 0,0,1,0
   localparam logic [3:0]  MODE_FAST_POR     = 4'hd;       // 1,1,0,1
   // system clock
   localparam int unsigned MCLK_MHZ          = 250;
   // power-on reset delays, least figures, in ms
   localparam int unsigned POR_FAST_MS       = 3;
   localparam int unsigned POR_STD_MS        = 50;
   localparam int unsigned POR_FAST_CYC      = POR_FAST_MS * MCLK_MHZ * 1000;
   localparam int unsigned POR_STD_CYC       = POR_STD_MS * MCLK_MHZ * 1000;
   // serial clock: highest rate in MHz, half period rounded up in cycles
   localparam int unsigned SCLK_MAX_MHZ      = 40;
   localparam int unsigned SCLK_HALF_CYC     = (MCLK_MHZ + 2 * SCLK_MAX_MHZ - 1)
                                               / (2 * SCLK_MAX_MHZ);
   // internal initialisation oscillator
   localparam int unsigned INIT_OSC_MHZ      = 10;
   localparam int unsigned INIT_DIV_CYC      = MCLK_MHZ / INIT_OSC_MHZ;
   localparam int unsigned INIT_CYCLES       = 3180;
   // error restart timeout, longest figure in us, rounded down
   localparam int unsigned RESTART_MAX_US    = 80;
   localparam int unsigned RESTART_CYC       = RESTART_MAX_US * MCLK_MHZ;
   // memory read command and address frame
   localparam logic [7:0]  READ_CMD          = 8'h03;
   localparam int unsigned CMD_BITS          = 32;
   // first frame of the bitstream: sync field and option bits
   localparam int unsigned HDR_BITS          = 32;
   localparam int unsigned HDR_SYNC_LSB      = 8;
   localparam int unsigned HDR_INITDONE_BIT  = 0;
   localparam logic [23:0] HDR_SYNC_DEFAULT  = 24'h5a3cc3;  // arbitrary value
   // loader stages
   typedef enum logic [2:0] {
      ST_POR      = 3'b000,
      ST_RESET    = 3'b001,
      ST_CONFIG   = 3'b010,
      ST_WAITDONE = 3'b011,
      ST_INIT     = 3'b100,
      ST_USER     = 3'b101,
      ST_ERROR    = 3'b110
   } ascm_state_t;
endpackage

// ==== core/ascm_tick_div.sv ====
// free divider that emits a one-cycle enable every DIV cycles while running
`timescale 1ns/1ps
module ascm_tick_div #(
   parameter int unsigned DIV = 4
) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic run,
   output logic      tick
);
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

   generate
      if (DIV < 2) begin : g_bad_div
         $error("ascm_tick_div needs DIV of at least 2");
      end
   endgenerate

   logic [W-1:0] cnt_reg;    // cycles since last tick
   logic [W-1:0] cnt_next;
   wire          atEnd = (cnt_reg == W'(DIV - 1));

   assign tick     = run && atEnd;
   assign cnt_next = (!run || atEnd) ? '0 : cnt_reg + W'(1);

   // counter restarts whenever the divider is stopped, so the first tick is a full period late
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule // ascm_tick_div

// ==== core/ascm_loader.sv ====
// self-driven serial configuration loader: power-on, reset, load, init, user mode
`timescale 1ns/1ps
module ascm_loader #(
   parameter int unsigned PorFastCycles = ascm_pkg::POR_FAST_CYC,   // fast power-on delay
   parameter int unsigned PorStdCycles  = ascm_pkg::POR_STD_CYC,    // standard power-on delay
   parameter int unsigned RestartCycles = ascm_pkg::RESTART_CYC,    // error reset timeout
   parameter int unsigned ConfigBits    = 1024,                     // bitstream length, with header
   parameter logic [23:0] HeaderSync    = ascm_pkg::HDR_SYNC_DEFAULT, // arbitrary value
   parameter logic [23:0] ReadAddress   = 24'h000000                // first memory address
) (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [3:0] modeSelectPins,
   input  wire logic       configRequestN,
   input  wire logic       statusLineIn,
   output logic            statusLineOut,
   output logic            statusLineOe,
   input  wire logic       configDoneLineIn,
   output logic            configDoneLineOut,
   output logic            configDoneLineOe,
   output logic            configSerialClock,
   output logic            configSerialClockOe,
   output logic            memorySelectOutN,
   output logic            memorySelectOe,
   output logic            serialCommandOut,
   output logic            serialCommandOe,
   input  wire logic       configDataIn,
   input  wire logic       userInitClock,
   input  wire logic       userClockEnable,
   input  wire logic       autoRestartEnable,
   output logic            initDoneOut,
   output logic            initDoneOe,
   output logic            userIoEnable,
   output logic            weakPullupEnable,
   output logic            configBitData,
   output logic            configBitValid,
   output logic            userModeActive
);
   generate
      if (ConfigBits <= ascm_pkg::HDR_BITS || PorFastCycles < 2 || PorStdCycles < 2
          || RestartCycles < 2) begin : g_bad_cfg
         $error("ascm_loader parameters out of range");
      end
   endgenerate

   localparam int unsigned LAST_FALL = ascm_pkg::CMD_BITS + ConfigBits - 1;

   // two-flop synchronisers for all pins except the user clock enable and auto-restart; order: request, status, done, data, user clock, mode
   logic [8:0]  syncA_reg;   // first stage, read only by the second
   logic [8:0]  syncB_reg;   // second stage, safe to use
   logic        userClkOld_reg;   // previous user clock level for edge finding
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         syncA_reg      <= 9'h003;
         syncB_reg      <= 9'h003;
         userClkOld_reg <= 1'b0;
      end else begin
         syncA_reg      <= {modeSelectPins, userInitClock, configDataIn, configDoneLineIn,
                            statusLineIn, configRequestN};
         syncB_reg      <= syncA_reg;
         userClkOld_reg <= syncB_reg[4];
      end
   end

   wire       reqHigh    = syncB_reg[0];
   wire       statusHigh = syncB_reg[1];
   wire       doneHigh   = syncB_reg[2];
   wire       dataBit    = syncB_reg[3];
   wire       userEdge   = syncB_reg[4] && !userClkOld_reg;
   wire [3:0] modeNow    = syncB_reg[8:5];
   wire       modeFast   = (modeNow == ascm_pkg::MODE_FAST_POR);
   wire       modeStd    = (modeNow == ascm_pkg::MODE_STD_POR);

   // state and working registers
   ascm_pkg::ascm_state_t state_reg, state_next;
   logic [31:0] cnt_reg;       // power-on, restart and init counter
   logic [31:0] cnt_next;
   logic [31:0] fallCnt_reg;   // serial clock falls in this load
   logic        sclk_reg;      // serial clock level
   logic        csN_reg;       // memory select, active low
   logic        cmdOut_reg;    // command bit toward memory
   logic [31:0] cmdShift_reg;  // remaining command and address bits
   logic [31:0] hdr_reg;       // first frame as it arrives
   logic        initDoneEn_reg;   // option bit from the first frame
   logic        bitData_reg;
   logic        bitValid_reg;

   // serial clock divider runs only while loading
   wire sclkTick;
   ascm_tick_div #(.DIV(ascm_pkg::SCLK_HALF_CYC)) u_sclk_div (
      .mclk (mclk),
      .nrst (nrst),
      .run  (state_reg == ascm_pkg::ST_CONFIG),
      .tick (sclkTick)
   );

   // internal init oscillator divider
   wire oscTick;
   ascm_tick_div #(.DIV(ascm_pkg::INIT_DIV_CYC)) u_osc_div (
      .mclk (mclk),
      .nrst (nrst),
      .run  (state_reg == ascm_pkg::ST_INIT),
      .tick (oscTick)
   );

   // the user clock is looked at only during init, so it cannot disturb loading
   wire initTick = userClockEnable ? userEdge : oscTick;

   // serial clock events
   wire fallEv   = sclkTick && sclk_reg;
   wire riseEv   = sclkTick && !sclk_reg;
   wire capture  = fallEv && (fallCnt_reg >= 32'(ascm_pkg::CMD_BITS));
   wire [31:0] dataIdx = fallCnt_reg - 32'(ascm_pkg::CMD_BITS);
   wire [31:0] hdrNew  = {hdr_reg[30:0], dataBit};
   wire hdrDone  = capture && (dataIdx == 32'(ascm_pkg::HDR_BITS - 1));
   wire hdrBad   = hdrDone && (hdrNew[31:ascm_pkg::HDR_SYNC_LSB] != HeaderSync);
   wire loadDone = fallEv && (fallCnt_reg == 32'(LAST_FALL));
   wire [31:0] porTarget  = modeFast ? 32'(PorFastCycles) : 32'(PorStdCycles);
   wire        porEnd     = (cnt_reg >= porTarget - 32'd1) && (modeFast || modeStd);
   wire        initEnd    = initTick && (cnt_reg == 32'(ascm_pkg::INIT_CYCLES - 1));
   wire        restartEnd = (cnt_reg == 32'(RestartCycles - 1));
   wire [31:0] cmdWord    = {ascm_pkg::READ_CMD, ReadAddress};

   // next stage; a low request wins over every stage after power-on
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ascm_pkg::ST_POR: begin
            cnt_next = cnt_reg + 32'd1;
            if (porEnd) begin
               state_next = ascm_pkg::ST_RESET;
               cnt_next   = '0;
            end
         end
         ascm_pkg::ST_RESET: begin
            if (reqHigh && statusHigh) begin
               state_next = ascm_pkg::ST_CONFIG;
            end
         end
         ascm_pkg::ST_CONFIG: begin
            if (hdrBad) begin
               state_next = ascm_pkg::ST_ERROR;
               cnt_next   = '0;
            end else if (loadDone) begin
               state_next = ascm_pkg::ST_WAITDONE;
            end
         end
         ascm_pkg::ST_WAITDONE: begin
            if (doneHigh) begin
               state_next = ascm_pkg::ST_INIT;
               cnt_next   = '0;
            end
         end
         ascm_pkg::ST_INIT: begin
            if (initEnd) begin
               state_next = ascm_pkg::ST_USER;
            end else if (initTick) begin
               cnt_next = cnt_reg + 32'd1;
            end
         end
         ascm_pkg::ST_USER: begin
            state_next = ascm_pkg::ST_USER;
         end
         ascm_pkg::ST_ERROR: begin
            // without auto-restart the stage holds until the system pulls the request low
            if (autoRestartEnable) begin
               cnt_next = cnt_reg + 32'd1;
               if (restartEnd) begin
                  state_next = ascm_pkg::ST_RESET;
               end
            end
         end
         default: begin
            state_next = ascm_pkg::ST_POR;
            cnt_next   = '0;
         end
      endcase
      if (state_reg != ascm_pkg::ST_POR && !reqHigh) begin
         state_next = ascm_pkg::ST_RESET;
         cnt_next   = '0;
      end
   end

   // stage register and shared counter
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ascm_pkg::ST_POR;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   wire enterConfig = (state_reg != ascm_pkg::ST_CONFIG) && (state_next == ascm_pkg::ST_CONFIG);
   wire inConfig    = (state_reg == ascm_pkg::ST_CONFIG) && (state_next == ascm_pkg::ST_CONFIG);

   // serial link: select changes on entry and exit, command on entry and on falls, data taken on falls
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sclk_reg     <= 1'b0;
         csN_reg      <= 1'b1;
         cmdOut_reg   <= 1'b0;
         cmdShift_reg <= '0;
         fallCnt_reg  <= '0;
      end else if (enterConfig) begin
         // clock is low here, so the first bit is set up before the first rise
         csN_reg      <= 1'b0;
         cmdOut_reg   <= cmdWord[31];
         cmdShift_reg <= {cmdWord[30:0], 1'b0};
         fallCnt_reg  <= '0;
         sclk_reg     <= 1'b0;
      end else if (inConfig) begin
         if (sclkTick) begin
            sclk_reg <= !sclk_reg;
         end
         if (fallEv) begin
            fallCnt_reg <= fallCnt_reg + 32'd1;
            if (fallCnt_reg < 32'(ascm_pkg::CMD_BITS - 1)) begin
               cmdOut_reg   <= cmdShift_reg[31];
               cmdShift_reg <= {cmdShift_reg[30:0], 1'b0};
            end
         end
      end else begin
         // leaving the load or idle: clock parked low, memory deselected
         sclk_reg   <= 1'b0;
         csN_reg    <= 1'b1;
         cmdOut_reg <= 1'b0;
      end
   end

   // first frame and data stream capture
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hdr_reg        <= '0;
         initDoneEn_reg <= 1'b0;
         bitData_reg    <= 1'b0;
         bitValid_reg   <= 1'b0;
      end else begin
         // the last bit falls on the edge that leaves the load, so the stage test is not used
         bitValid_reg <= capture && !hdrBad;
         if (capture) begin
            bitData_reg <= dataBit;
            hdr_reg     <= hdrNew;
         end
         if (enterConfig) begin
            initDoneEn_reg <= 1'b0;
         end else if (hdrDone && !hdrBad) begin
            initDoneEn_reg <= hdrNew[ascm_pkg::HDR_INITDONE_BIT];
         end
      end
   end

   // pin drive decoding; open-drain lines only ever pull low
   wire stPor     = (state_reg == ascm_pkg::ST_POR);
   wire stError   = (state_reg == ascm_pkg::ST_ERROR);
   wire stUser    = (state_reg == ascm_pkg::ST_USER);
   wire doneFree  = (state_reg == ascm_pkg::ST_WAITDONE) || (state_reg == ascm_pkg::ST_INIT)
                    || stUser;
   wire linkDrive = (state_reg == ascm_pkg::ST_CONFIG);

   assign statusLineOut       = 1'b0;
   assign statusLineOe        = stPor || stError || !reqHigh;
   assign configDoneLineOut   = 1'b0;
   assign configDoneLineOe    = !doneFree;
   assign configSerialClock   = sclk_reg;
   assign configSerialClockOe = linkDrive;
   assign memorySelectOutN    = csN_reg;
   assign memorySelectOe      = !stPor && !stUser;
   assign serialCommandOut    = cmdOut_reg;
   assign serialCommandOe     = linkDrive;
   assign initDoneOut         = 1'b0;
   assign initDoneOe          = initDoneEn_reg && !stUser && !stPor;
   assign userIoEnable        = stUser;
   assign weakPullupEnable    = !stPor && !stUser;
   assign configBitData       = bitData_reg;
   assign configBitValid      = bitValid_reg;
   assign userModeActive      = stUser;

   // checks next to the logic
   por_status_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      stPor |-> statusLineOe && configDoneLineOe && !userIoEnable)
      else $error("status or done released during power-on");

   reset_hold_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      (state_reg == ascm_pkg::ST_RESET) && (!reqHigh || !statusHigh)
      |=> (state_reg == ascm_pkg::ST_RESET))
      else $error("reset stage left while request or status low");

   clock_park_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      !linkDrive |-> !sclk_reg && csN_reg)
      else $error("serial clock or select active outside loading");

   cmd_on_fall_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      linkDrive && $changed(cmdOut_reg) |-> !sclk_reg)
      else $error("command bit changed away from a falling edge");

   capture_fall_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      bitValid_reg |-> !sclk_reg && $past(sclk_reg))
      else $error("data bit captured away from a falling edge");

   select_low_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      linkDrive && $past(linkDrive) |-> !csN_reg)
      else $error("memory not selected during loading");

   init_count_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      $rose(stUser) |-> $past(cnt_reg) == 32'(ascm_pkg::INIT_CYCLES - 1) && $past(initTick))
      else $error("user mode entered before init count");

   init_gate_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      (state_reg == ascm_pkg::ST_INIT) && $past(state_reg == ascm_pkg::ST_WAITDONE)
      |-> $past(doneHigh))
      else $error("init started without done line high");

   error_lines_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      stError |-> statusLineOe && configDoneLineOe ##0 !userIoEnable)
      else $error("error stage not holding status and done low");

   user_pins_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      stUser |-> !weakPullupEnable && userIoEnable && !initDoneOe)
      else $error("user mode pins wrong");

   request_low_a: assert property (
      @(posedge mclk) disable iff (!nrst)
      !stPor && !reqHigh |-> statusLineOe ##1 (state_reg == ascm_pkg::ST_RESET))
      else $error("low request did not reset");
endmodule // ascm_loader

// ==== verif/ascm_flash_model.sv ====
// serial configuration memory model: takes the read command, streams the bitstream back
`timescale 1ns/1ps
module ascm_flash_model #(
   parameter int unsigned ConfigBits = 64
) (
   input  wire logic                  sclk,
   input  wire logic                  csN,
   input  wire logic                  cmdIn,
   input  wire logic [ConfigBits-1:0] image,
   output logic                       dataOut,
   output logic                       cmdOk
);
   logic [31:0] cmdReg;  // command and address as shifted in
   int          nRise;   // rising edges seen since selection
   int          nOut;    // data bits already launched

   initial begin
      dataOut = 1'b1;
      cmdOk   = 1'b0;
      nRise   = 0;
      nOut    = 0;
   end

   // command and address bits are taken on rising edges while selected
   always @(posedge sclk) begin
      if (!csN && nRise < 32) begin
         cmdReg = {cmdReg[30:0], cmdIn};
         nRise++;
         if (nRise == 32) begin
            cmdOk = (cmdReg === {ascm_pkg::READ_CMD, 24'h000000});
         end
      end
   end

   // data goes out on falls, the first one right after the last command bit
   always @(negedge sclk) begin
      if (!csN && nRise == 32 && nOut < ConfigBits) begin
         dataOut = image[ConfigBits-1-nOut];
         nOut++;
      end
   end

   // deselect ends the read; the line then floats to its weak pull-up level
   always @(posedge csN) begin
      nRise   = 0;
      nOut    = 0;
      dataOut = 1'b1;
   end
endmodule  // ascm_flash_model

// ==== verif/ascm_loader_bench.sv ====
// self-checking bench for the serial configuration loader
`timescale 1ns/1ps
module ascm_loader_bench;
   localparam int unsigned Bits = 64;  // short bitstream keeps loads under 800 cycles
   logic            mclk, nrst, configRequestN, userInitClock, userClockEnable;
   logic            autoRestartEnable, runUser, cmdOk, memData;
   logic [3:0]      modeSelectPins;
   logic            statusLineOut, statusLineOe, configDoneLineOut, configDoneLineOe;
   logic            configSerialClock, configSerialClockOe, memorySelectOutN, memorySelectOe;
   logic            serialCommandOut, serialCommandOe, initDoneOut, initDoneOe;
   logic            userIoEnable, weakPullupEnable, configBitData, configBitValid;
   logic            userModeActive;
   logic [Bits-1:0] image;       // memory contents, header first
   logic [31:0]     payload;     // random body of the bitstream
   logic            expBits[$];  // bits the loader should hand out, oldest first
   int              seed, miscompares, nChecks, userEdges;
   // open-drain wires with external pull-ups
   wire statusWire   = ~(statusLineOe & ~statusLineOut);
   wire doneWire     = ~(configDoneLineOe & ~configDoneLineOut);
   wire initDoneWire = ~(initDoneOe & ~initDoneOut);

   ascm_loader #(.PorFastCycles(20), .PorStdCycles(30), .RestartCycles(40),
      .ConfigBits(Bits)) ascm_loader_inst (
      .mclk(mclk), .nrst(nrst), .modeSelectPins(modeSelectPins),
      .configRequestN(configRequestN), .statusLineIn(statusWire),
      .statusLineOut(statusLineOut), .statusLineOe(statusLineOe),
      .configDoneLineIn(doneWire), .configDoneLineOut(configDoneLineOut),
      .configDoneLineOe(configDoneLineOe), .configSerialClock(configSerialClock),
      .configSerialClockOe(configSerialClockOe), .memorySelectOutN(memorySelectOutN),
      .memorySelectOe(memorySelectOe), .serialCommandOut(serialCommandOut),
      .serialCommandOe(serialCommandOe), .configDataIn(memData),
      .userInitClock(userInitClock), .userClockEnable(userClockEnable),
      .autoRestartEnable(autoRestartEnable), .initDoneOut(initDoneOut),
      .initDoneOe(initDoneOe), .userIoEnable(userIoEnable),
      .weakPullupEnable(weakPullupEnable), .configBitData(configBitData),
      .configBitValid(configBitValid), .userModeActive(userModeActive));

   // released link pins sit at their weak pull-up level
   ascm_flash_model #(.ConfigBits(Bits)) ascm_flash_model_inst (
      .sclk(configSerialClockOe ? configSerialClock : 1'b1),
      .csN(memorySelectOe ? memorySelectOutN : 1'b1),
      .cmdIn(serialCommandOe ? serialCommandOut : 1'b1),
      .image(image), .dataOut(memData), .cmdOk(cmdOk));

   // system clock, 4 ns
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // user init clock, 48 ns, edges on system clock falls; stands still when not wanted
   always #24 if (runUser) userInitClock = ~userInitClock;
   always @(posedge userInitClock) userEdges++;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && nChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // oldest expected bit is taken off whenever the loader hands one out
   always @(negedge mclk) begin
      if (configBitValid === 1'b1 && expBits.size() > 0) begin
         check("config bit", {31'h0, configBitData}, {31'h0, expBits.pop_front()});
      end
   end

   // codes: 0 done wire, 1 user mode, 2 memory select, 3 status wire
   function automatic logic sigOf(input int k);
      case (k)
         0: return doneWire;
         1: return userModeActive;
         2: return memorySelectOutN;
         default: return statusWire;
      endcase
   endfunction

   // bounded wait for a level; running out counts as a mismatch
   task automatic waitLevel(input int k, input logic lvl, input int lim);
      int i;
      i = 0;
      while (sigOf(k) !== lvl && i < lim) begin
         @(negedge mclk);
         i++;
      end
      check($sformatf("level of signal %0d", k), {31'h0, sigOf(k)}, {31'h0, lvl});
   endtask

   // sets the memory image; a good header also queues every bit it should yield
   task automatic loadImage(input logic badHdr);
      image = {ascm_pkg::HDR_SYNC_DEFAULT ^ {23'h0, badHdr}, 7'h00, 1'b1, payload};
      if (!badHdr) for (int i = Bits - 1; i >= 0; i--) expBits.push_back(image[i]);
   endtask

   // request pulse of 500 ns
   task automatic pulseRequest;
      configRequestN = 1'b0;
      repeat (125) @(negedge mclk);
      configRequestN = 1'b1;
   endtask

   task automatic powerUp(input logic [3:0] mode);
      nrst           = 1'b0;
      modeSelectPins = mode;
      repeat (4) @(negedge mclk);
      nrst = 1'b1;
   endtask

   // watchdog well beyond the expected run of about 45000 cycles
   initial begin
      #400000;
      miscompares++;
      report_and_stop;
   end

   initial begin
      seed = 71; nrst = 1'b0; modeSelectPins = 4'hd; configRequestN = 1'b1;
      userInitClock = 1'b0; userClockEnable = 1'b1; autoRestartEnable = 1'b0;
      runUser = 1'b1; miscompares = 0; nChecks = 0; userEdges = 0;
      payload = $random(seed);
      loadImage(1'b0);
      // fast power-on; a request pulse inside it has no effect
      powerUp(4'hd);
      configRequestN = 1'b0;
      repeat (12) @(negedge mclk);
      configRequestN = 1'b1;
      repeat (6) @(negedge mclk);
      check("status in power-on", statusWire, 0);
      check("done in power-on", doneWire, 0);
      check("io in power-on", userIoEnable, 0);
      check("select in power-on", memorySelectOutN, 1);
      waitLevel(2, 1'b0, 20);
      check("status after power-on", statusWire, 1);
      // load runs with the user clock toggling; it must not disturb the load
      waitLevel(0, 1'b1, 2000);
      runUser = 1'b0;
      repeat (2) @(negedge mclk);
      check("bits left", expBits.size(), 0);
      check("command word", cmdOk, 1);
      check("serial clock idle", configSerialClock, 0);
      check("select idle", memorySelectOutN, 1);
      check("init-complete low", initDoneWire, 0);
      check("pull-ups in init", weakPullupEnable, 1);
      repeat (500) @(negedge mclk);
      check("user mode with user clock still", userModeActive, 0);
      userEdges = 0;
      runUser = 1'b1;
      waitLevel(1, 1'b1, 40000);
      runUser = 1'b0;
      check("init clock count", userEdges, ascm_pkg::INIT_CYCLES);
      check("init-complete released", initDoneWire, 1);
      check("io in user mode", userIoEnable, 1);
      check("pull-ups in user mode", weakPullupEnable, 0);
      // reconfigure into a bad header, no automatic restart
      loadImage(1'b1);
      configRequestN = 1'b0;
      repeat (125) @(negedge mclk);
      check("status on request", statusWire, 0);
      check("done on request", doneWire, 0);
      check("io on request", userIoEnable, 0);
      configRequestN = 1'b1;
      waitLevel(2, 1'b0, 40);
      waitLevel(3, 1'b0, 2000);
      repeat (200) @(negedge mclk);
      check("status held in error", statusWire, 0);
      check("done held in error", doneWire, 0);
      loadImage(1'b0);
      pulseRequest();
      waitLevel(0, 1'b1, 2000);
      repeat (2) @(negedge mclk);
      check("bits left after retry", expBits.size(), 0);
      // bad header with automatic restart, then a good retry
      autoRestartEnable = 1'b1;
      loadImage(1'b1);
      pulseRequest();
      waitLevel(2, 1'b0, 40);
      waitLevel(3, 1'b0, 2000);
      check("select pulsed high", memorySelectOutN, 1);
      loadImage(1'b0);
      waitLevel(3, 1'b1, 50);
      waitLevel(2, 1'b0, 20);
      waitLevel(0, 1'b1, 2000);
      repeat (2) @(negedge mclk);
      check("bits left after restart", expBits.size(), 0);
      // standard power-on delay
      powerUp(4'h2);
      repeat (25) @(negedge mclk);
      check("select in standard power-on", memorySelectOutN, 1);
      waitLevel(2, 1'b0, 30);
      // unknown mode code keeps the device in power-on
      powerUp(4'h7);
      repeat (100) @(negedge mclk);
      check("status with unknown mode", statusWire, 0);
      check("select with unknown mode", memorySelectOutN, 1);
      report_and_stop;
   end
endmodule  // ascm_loader_bench
